// [include/pdcs_map.svh]
// Register map, field positions, reset values and timing constants of the device control block.
`ifndef PDCS_MAP_SVH
`define PDCS_MAP_SVH
`define PDCS_OFS_CAP      8'hb4
`define PDCS_OFS_CTLSTS   8'hb8
`define PDCS_OFS_IRQ_STS  8'hd0
`define PDCS_OFS_IRQ_MSK  8'hd4
`define PDCS_L1_LAT_RST   3'h0
`define PDCS_L1_LAT_MAX   3'h7
`define PDCS_L1_LAT_LSB   9
`define PDCS_HP_LSB       12
`define PDCS_SPL_VAL_LSB  18
`define PDCS_SPL_SCL_LSB  26
`define PDCS_CTL_WMASK    16'hf1ef
`define PDCS_CTL_RST      16'h2000
`define PDCS_STS_AUX      16'h0010
`define PDCS_STS_ERR_MASK 16'h000f
`define PDCS_PEND_BIT     5
`define PDCS_SYNC_STAGES  2
`endif

// [include/pdcs_pkg.sv]
// Types shared by the device control block files.
`default_nettype none
package pdcs_pkg;
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} pdcs_bus_req_t;
	typedef struct packed {
		logic [7:0] value;
		logic [1:0] scale;
		logic       valid;
	} pdcs_spl_msg_t;
	typedef enum logic [1:0] {
		PDCS_RD_IDLE = 2'b00,
		PDCS_RD_DATA = 2'b01
	} pdcs_rd_state_t;
endpackage : pdcs_pkg
`default_nettype wire

// [hw/pdcs_sync.sv]
// Two flip-flop synchroniser for pin-level inputs.
`timescale 1ns/10ps
`default_nettype none
module pdcs_sync (
	// Clock and reset
	input  wire logic i_mclk,
	input  wire logic i_rst,
	// Data
	input  wire logic i_d,
	output var  logic o_q
);
	typedef struct packed {
		logic s1;
		logic s2;
	} pdcs_sync_st_t;
	pdcs_sync_st_t st_r;
	pdcs_sync_st_t st_nxt;
	always_comb begin
		st_nxt    = st_r;
		st_nxt.s1 = i_d;
		st_nxt.s2 = st_r.s1;
	end
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign o_q = st_r.s2;
endmodule : pdcs_sync
`default_nettype wire

// [hw/pdcs_irq.sv]
// Sticky event status with mask and level interrupt output.
`timescale 1ns/10ps
`default_nettype none
module pdcs_irq (
	// Clock and reset
	input  wire logic       i_mclk,
	input  wire logic       i_rst,
	// Events and software access
	input  wire logic [3:0] i_evt,
	input  wire logic [3:0] i_clr,
	input  wire logic       i_msk_wr,
	input  wire logic [3:0] i_msk_wdata,
	// State
	output var  logic [3:0] o_sts,
	output var  logic [3:0] o_msk,
	output var  logic       o_irq
);
	typedef struct packed {
		logic [3:0] sts;
		logic [3:0] msk;
		logic       irq;
	} pdcs_irq_st_t;
	pdcs_irq_st_t st_r;
	pdcs_irq_st_t st_nxt;
	always_comb begin
		st_nxt = st_r;
		// A set in the same cycle as a clear wins, so no event is lost.
		st_nxt.sts = (st_r.sts & ~i_clr) | i_evt;
		if (i_msk_wr) begin
			st_nxt.msk = i_msk_wdata;
		end
		st_nxt.irq = |(st_nxt.sts & st_nxt.msk);
	end
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign o_sts = st_r.sts;
	assign o_msk = st_r.msk;
	assign o_irq = st_r.irq;
	// Each flag is checked on its own lane, so a stuck bit anywhere is caught.
	for (genvar k = 0; k < 4; k++) begin : g_flag_chk
		sticky_set_a: assert property (@(posedge i_mclk) disable iff (i_rst)
			i_evt[k] |=> o_sts[k])
			else $error("error flag lost");
		sticky_hold_a: assert property (@(posedge i_mclk) disable iff (i_rst)
			(o_sts[k] && !i_clr[k]) |=> o_sts[k])
			else $error("error flag dropped");
		flag_clear_a: assert property (@(posedge i_mclk) disable iff (i_rst)
			(o_sts[k] && i_clr[k] && !i_evt[k]) |=> !o_sts[k])
			else $error("error flag not cleared");
	end
endmodule : pdcs_irq
`default_nettype wire

// [hw/pdcs_regs.sv]
// Device capability, control and status registers with error interrupt.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "pdcs_map.svh"
module pdcs_regs
	import pdcs_pkg::*;
(
	// Clock and reset
	input  wire logic          i_mclk,
	input  wire logic          i_rst,
	// Register port
	input  wire logic [7:0]    i_addr,
	input  wire logic [31:0]   i_wdata,
	input  wire logic          i_wr,
	input  wire logic          i_rd,
	output logic      [31:0]   o_rdata,
	// Strap pin and link message
	input  wire logic          i_hp_strap,
	input  wire pdcs_spl_msg_t i_spl_msg,
	// Transaction layer and error detectors
	input  wire logic          i_txn_pending,
	input  wire logic [3:0]    i_err_evt,
	// Control outputs to the bridge core
	output logic      [3:0]    o_err_rpt_en,
	output logic      [2:0]    o_max_payload,
	output logic      [2:0]    o_max_rd_req,
	output logic               o_ext_tag_en,
	output logic               o_cfg_retry_en,
	output logic               o_no_snoop,
	// Interrupt
	output logic               o_irq
);
	typedef struct packed {
		logic [31:0] rdata;
		logic [15:0] ctl;
		logic [7:0]  spl_val;
		logic [1:0]  spl_scl;
		logic        pend;
		logic        hp;
	} pdcs_regs_st_t;
	pdcs_regs_st_t st_r;
	pdcs_regs_st_t st_nxt;
	pdcs_bus_req_t req;
	logic          hp_sync;
	logic [3:0]    err_sts;
	logic [3:0]    err_msk;
	logic [3:0]    err_clr;
	logic          msk_wr;
	logic [31:0]   cap_word;
	logic [31:0]   ctlsts_word;
	logic          irq_w;

	// The strap is a pin, so it is synchronised before use.
	pdcs_sync u_hp_sync (
		.i_mclk (i_mclk),
		.i_rst  (i_rst),
		.i_d    (i_hp_strap),
		.o_q    (hp_sync)
	);

	assign req     = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
	assign err_clr = (req.wr && req.addr == `PDCS_OFS_CTLSTS) ? req.wdata[19:16] : 4'h0;
	assign msk_wr  = req.wr && req.addr == `PDCS_OFS_IRQ_MSK;

	pdcs_irq u_irq (
		.i_mclk      (i_mclk),
		.i_rst       (i_rst),
		.i_evt       (i_err_evt),
		.i_clr       (err_clr | ((req.wr && req.addr == `PDCS_OFS_IRQ_STS) ?
		              req.wdata[3:0] : 4'h0)),
		.i_msk_wr    (msk_wr),
		.i_msk_wdata (req.wdata[3:0]),
		.o_sts       (err_sts),
		.o_msk       (err_msk),
		.o_irq       (irq_w)
	);

	always_comb begin
		cap_word = 32'h0;
		// The device has no L1 latency tolerance to report beyond the reset code.
		cap_word[`PDCS_L1_LAT_LSB +: 3]  = `PDCS_L1_LAT_RST;
		cap_word[`PDCS_HP_LSB +: 3]      = {3{st_r.hp}};
		cap_word[`PDCS_SPL_VAL_LSB +: 8] = st_r.spl_val;
		cap_word[`PDCS_SPL_SCL_LSB +: 2] = st_r.spl_scl;
	end

	always_comb begin
		ctlsts_word        = 32'h0;
		ctlsts_word[15:0]  = st_r.ctl & `PDCS_CTL_WMASK;
		ctlsts_word[31:16] = {10'h0, st_r.pend, 1'b0, err_sts} | `PDCS_STS_AUX;
	end

	always_comb begin
		st_nxt      = st_r;
		st_nxt.hp   = hp_sync;
		st_nxt.pend = i_txn_pending;
		if (i_spl_msg.valid) begin
			st_nxt.spl_val = i_spl_msg.value;
			st_nxt.spl_scl = i_spl_msg.scale;
		end
		if (req.wr && req.addr == `PDCS_OFS_CTLSTS) begin
			// Read-only control bits are masked off so they always read zero.
			st_nxt.ctl = req.wdata[15:0] & `PDCS_CTL_WMASK;
		end
		st_nxt.rdata = 32'h0;
		if (req.rd) begin
			case (req.addr)
				`PDCS_OFS_CAP:     st_nxt.rdata = cap_word;
				`PDCS_OFS_CTLSTS:  st_nxt.rdata = ctlsts_word;
				`PDCS_OFS_IRQ_STS: st_nxt.rdata = {28'h0, err_sts};
				`PDCS_OFS_IRQ_MSK: st_nxt.rdata = {28'h0, err_msk};
				default:           st_nxt.rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			st_r     <= '0;
			st_r.ctl <= `PDCS_CTL_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_rdata        = st_r.rdata;
	assign o_err_rpt_en   = st_r.ctl[3:0];
	assign o_max_payload  = st_r.ctl[7:5];
	assign o_max_rd_req   = st_r.ctl[14:12];
	assign o_ext_tag_en   = st_r.ctl[8];
	assign o_cfg_retry_en = st_r.ctl[15];
	assign o_no_snoop     = st_r.ctl[11];
	assign o_irq          = irq_w;

	// Control word writes land in the cycle after the strobe and hold until the next one.
	ctl_write_a: assert property (@(posedge i_mclk) disable iff (i_rst)
		(i_wr && i_addr == `PDCS_OFS_CTLSTS) |=> o_max_payload == $past(i_wdata[7:5]))
		else $error("payload field not written");
	rdreq_write_a: assert property (@(posedge i_mclk) disable iff (i_rst)
		(i_wr && i_addr == `PDCS_OFS_CTLSTS) |=> o_max_rd_req == $past(i_wdata[14:12]))
		else $error("read request field not written");
	err_en_a: assert property (@(posedge i_mclk) disable iff (i_rst)
		(i_wr && i_addr == `PDCS_OFS_CTLSTS) |=> o_err_rpt_en == $past(i_wdata[3:0]))
		else $error("error enables not written");
	ext_tag_a: assert property (@(posedge i_mclk) disable iff (i_rst)
		(i_wr && i_addr == `PDCS_OFS_CTLSTS) |=> o_ext_tag_en == $past(i_wdata[8]))
		else $error("extended tag not written");
	retry_write_a: assert property (@(posedge i_mclk) disable iff (i_rst)
		(i_wr && i_addr == `PDCS_OFS_CTLSTS) |=> o_cfg_retry_en == $past(i_wdata[15]))
		else $error("retry enable not written");
	ctl_hold_a: assert property (@(posedge i_mclk) disable iff (i_rst)
		!(i_wr && i_addr == `PDCS_OFS_CTLSTS) |=> ($stable(o_err_rpt_en)
		&& $stable(o_max_payload) && $stable(o_max_rd_req) && $stable(o_ext_tag_en)
		&& $stable(o_cfg_retry_en))) else $error("control outputs changed without a write");
	ro_zero_a: assert property (@(posedge i_mclk) disable iff (i_rst)
		(i_rd && i_addr == `PDCS_OFS_CTLSTS) |=> (o_rdata[4] == 1'b0 && o_rdata[11:9] == 3'h0
		&& o_rdata[20] == 1'b1)) else $error("fixed control bits wrong");
	no_snoop_a: assert property (@(posedge i_mclk) disable iff (i_rst)
		!o_no_snoop) else $error("no snoop set");

	// The pending bit lags the transaction layer by one cycle.
	sts_reserved_a: assert property (@(posedge i_mclk) disable iff (i_rst)
		(i_rd && i_addr == `PDCS_OFS_CTLSTS) |=> o_rdata[31:22] == 10'h0)
		else $error("reserved status bits set");
	txn_pending_a: assert property (@(posedge i_mclk) disable iff (i_rst)
		(i_txn_pending ##1 (i_rd && i_addr == `PDCS_OFS_CTLSTS)) |=> o_rdata[21])
		else $error("pending not shown");
	pend_clear_a: assert property (@(posedge i_mclk) disable iff (i_rst)
		(!i_txn_pending ##1 (i_rd && i_addr == `PDCS_OFS_CTLSTS)) |=> !o_rdata[21])
		else $error("pending shown while idle");

	// Capability word.
	spl_load_a: assert property (@(posedge i_mclk) disable iff (i_rst)
		i_spl_msg.valid ##1 (i_rd && i_addr == `PDCS_OFS_CAP && !i_spl_msg.valid)
		|=> o_rdata[27:18] == {$past(i_spl_msg.scale, 2), $past(i_spl_msg.value, 2)})
		else $error("slot power not captured");
	spl_hold_a: assert property (@(posedge i_mclk) disable iff (i_rst)
		!i_spl_msg.valid |=> ($stable(st_r.spl_val) && $stable(st_r.spl_scl)))
		else $error("slot power changed without a message");
	hp_bits_a: assert property (@(posedge i_mclk) disable iff (i_rst)
		(i_rd && i_addr == `PDCS_OFS_CAP) |=> o_rdata[14:12] == {3{o_rdata[12]}}
		&& o_rdata[11:9] == `PDCS_L1_LAT_RST) else $error("capability bits wrong");
	// The strap must be steady through the two synchroniser stages and the capture flop.
	hp_on_a: assert property (@(posedge i_mclk) disable iff (i_rst)
		(i_hp_strap [*4] ##0 (i_rd && i_addr == `PDCS_OFS_CAP)) |=> o_rdata[14:12] == 3'h7)
		else $error("hot plug bits not set");
	hp_off_a: assert property (@(posedge i_mclk) disable iff (i_rst)
		(!i_hp_strap [*4] ##0 (i_rd && i_addr == `PDCS_OFS_CAP)) |=> o_rdata[14:12] == 3'h0)
		else $error("hot plug bits not clear");
	cap_reserved_a: assert property (@(posedge i_mclk) disable iff (i_rst)
		(i_rd && i_addr == `PDCS_OFS_CAP) |=> (o_rdata[31:28] == 4'h0 && o_rdata[17:15] == 3'h0
		&& o_rdata[8:0] == 9'h0)) else $error("reserved capability bits set");

	// Error flags and interrupt.
	err_w1c_a: assert property (@(posedge i_mclk) disable iff (i_rst)
		(i_wr && i_addr == `PDCS_OFS_CTLSTS)
		|=> (err_sts & $past(i_wdata[19:16] & ~i_err_evt)) == 4'h0)
		else $error("error flag not cleared by write");
	mask_write_a: assert property (@(posedge i_mclk) disable iff (i_rst)
		(i_wr && i_addr == `PDCS_OFS_IRQ_MSK) |=> err_msk == $past(i_wdata[3:0]))
		else $error("interrupt mask not written");
	irq_level_a: assert property (@(posedge i_mclk) disable iff (i_rst)
		o_irq == |(err_sts & err_msk)) else $error("interrupt level wrong");

	// Read port: data stand for one cycle only, and unmapped offsets read zero.
	rdata_idle_a: assert property (@(posedge i_mclk) disable iff (i_rst)
		!i_rd |=> o_rdata == 32'h0) else $error("read data outside read cycle");
	unmapped_rd_a: assert property (@(posedge i_mclk) disable iff (i_rst)
		(i_rd && i_addr != `PDCS_OFS_CAP && i_addr != `PDCS_OFS_CTLSTS
		&& i_addr != `PDCS_OFS_IRQ_STS && i_addr != `PDCS_OFS_IRQ_MSK) |=> o_rdata == 32'h0)
		else $error("unmapped read not zero");
endmodule : pdcs_regs
`default_nettype wire

// [tb/pdcs_link_model.sv]
// Upstream link partner model that sends slot power limit messages.
`timescale 1ns/10ps
`default_nettype none
module pdcs_link_model
	import pdcs_pkg::*;
(
	// Clock
	input  wire logic          i_mclk,
	// Message request: value in [9:2], scale in [1:0]
	input  wire logic          i_send,
	input  wire logic [9:0]    i_msg,
	// Message to the device
	output var  pdcs_spl_msg_t o_spl_msg
);
	pdcs_spl_msg_t msg_r = '0;
	assign o_spl_msg = msg_r;
	// Between messages the payload toggles, so a stale value never passes for data.
	always_ff @(posedge i_mclk) begin
		msg_r.valid <= i_send;
		msg_r.value <= i_send ? i_msg[9:2] : ~msg_r.value;
		msg_r.scale <= i_send ? i_msg[1:0] : ~msg_r.scale;
	end
endmodule : pdcs_link_model
`default_nettype wire

// [tb/test_pcie_device_ctrl_status_regs.sv]
// Self-checking bench for the device control and status registers.
`timescale 1ns/10ps
`default_nettype none
module test_pcie_device_ctrl_status_regs
	import pdcs_pkg::*;
;
	logic          i_mclk = 1'b0;
	logic          i_rst = 1'b1;
	logic [7:0]    addr = 8'h00;
	logic [31:0]   wdata = 32'h0, rdata;
	logic          wr = 1'b0, rd = 1'b0, hp = 1'b0, pend = 1'b0, send = 1'b0;
	logic [9:0]    msg = 10'h0;
	logic [3:0]    err = 4'h0, rpt;
	logic [2:0]    mps, mrr;
	logic          etag, retry, nsnoop, irq;
	pdcs_spl_msg_t spl;
	int            mismatches = 0, cmp_count = 0;

	always #5 i_mclk = ~i_mclk;

	pdcs_link_model u_link (.i_mclk(i_mclk), .i_send(send), .i_msg(msg), .o_spl_msg(spl));
	pdcs_regs dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
		.i_rd(rd), .o_rdata(rdata), .i_hp_strap(hp), .i_spl_msg(spl), .i_txn_pending(pend),
		.i_err_evt(err), .o_err_rpt_en(rpt), .o_max_payload(mps), .o_max_rd_req(mrr),
		.o_ext_tag_en(etag), .o_cfg_retry_en(retry), .o_no_snoop(nsnoop), .o_irq(irq));

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge i_mclk);
		wr <= 1'b0;
	endtask : wr_reg

	// Read data stand only in the cycle after the strobe, so they are sampled mid-cycle there.
	task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
		@(posedge i_mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge i_mclk);
		rd <= 1'b0;
		@(negedge i_mclk);
		chk("rdata", exp, rdata);
	endtask : rd_reg

	task automatic ctl_chk(input logic [12:0] exp);
		@(negedge i_mclk);
		chk("ctl_out", {19'h0, exp}, {19'h0, rpt, mps, mrr, etag, retry, nsnoop});
	endtask : ctl_chk

	task automatic complete_run;
		if (mismatches == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : complete_run

	initial begin
		repeat (5000) @(posedge i_mclk);
		mismatches++;
		complete_run();
	end

	initial begin
		repeat (20) @(posedge i_mclk);
		i_rst <= 1'b0;
		rd_reg(8'hb4, 32'h0);
		rd_reg(8'hb8, 32'h0010_2000);
		ctl_chk({4'h0, 3'h0, 3'h2, 3'h0});
		wr_reg(8'hb8, 32'hffff_ffff);
		ctl_chk({4'hf, 3'h7, 3'h7, 3'h6});
		rd_reg(8'hb8, 32'h0010_f1ef);
		for (int c = 0; c < 6; c++) begin
			wr_reg(8'hb8, {17'h0, 3'(c), 4'h0, 3'(c), 5'h0});
			ctl_chk({4'h0, 3'(c), 3'(c), 3'h0});
		end
		@(posedge i_mclk);
		hp <= 1'b1;
		pend <= 1'b1;
		repeat (4) @(posedge i_mclk);
		wr_reg(8'hb4, 32'hffff_ffff);
		rd_reg(8'hb4, 32'h0000_7000);
		@(posedge i_mclk);
		msg <= {8'ha5, 2'h2};
		send <= 1'b1;
		@(posedge i_mclk);
		send <= 1'b0;
		rd_reg(8'hb4, 32'h0a94_7000);
		rd_reg(8'hb8, 32'h0030_50a0);
		@(posedge i_mclk);
		pend <= 1'b0;
		err <= 4'hf;
		@(posedge i_mclk);
		err <= 4'h0;
		rd_reg(8'hb8, 32'h001f_50a0);
		chk("irq", 32'h0, {31'h0, irq});
		wr_reg(8'hd4, 32'h0000_000f);
		rd_reg(8'hd4, 32'h0000_000f);
		chk("irq", 32'h1, {31'h0, irq});
		wr_reg(8'hb8, 32'h0001_50a0);
		rd_reg(8'hb8, 32'h001e_50a0);
		rd_reg(8'hd0, 32'h0000_000e);
		wr_reg(8'hd0, 32'h0000_000e);
		rd_reg(8'hb8, 32'h0010_50a0);
		chk("irq", 32'h0, {31'h0, irq});
		// An error event in the same cycle as its clear must leave the flag set.
		@(posedge i_mclk);
		addr <= 8'hd0;
		wdata <= 32'h0000_0001;
		wr <= 1'b1;
		err <= 4'h1;
		@(posedge i_mclk);
		wr <= 1'b0;
		err <= 4'h0;
		rd_reg(8'hd0, 32'h0000_0001);
		chk("irq", 32'h1, {31'h0, irq});
		// A reset in mid-run must bring back the control, status and capability reset values.
		@(posedge i_mclk);
		i_rst <= 1'b1;
		repeat (3) @(posedge i_mclk);
		i_rst <= 1'b0;
		rd_reg(8'hb8, 32'h0010_2000);
		rd_reg(8'hb4, 32'h0000_7000);
		ctl_chk({4'h0, 3'h0, 3'h2, 3'h0});
		chk("irq", 32'h0, {31'h0, irq});
		wr_reg(8'h40, 32'hffff_ffff);
		rd_reg(8'h40, 32'h0);
		complete_run();
	end
endmodule : test_pcie_device_ctrl_status_regs
`default_nettype wire
